// *** verilog/phy_control_register.sv ***
// transceiver control register with APB slave, self-test and LED control
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

module phy_control_register
    import phy_ctrl_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = STRETCH_CYC,
    parameter int unsigned BLINK_CYCLES   = BLINK_CYC
)(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               strap_auto_crossover,
    input  wire logic               strap_led_mode,
    input  wire logic [ADDR_W-1:0]  strap_address,
    input  wire logic               an_result_valid,
    input  wire logic               an_full_duplex,
    input  wire logic [1:0]         local_pause_ability,
    input  wire logic [1:0]         partner_pause_ability,
    input  wire logic               link_good,
    input  wire logic               activity,
    input  wire logic               speed_100,
    input  wire logic               selftest_rx_bit,
    output logic                    selftest_tx_bit,
    output logic                    auto_crossover_enable,
    output logic                    crossover_force,
    output logic                    pause_rx_enable,
    output logic                    pause_tx_enable,
    output logic [ADDR_W-1:0]       management_address,
    output logic                    link_indicator,
    output logic                    speed_indicator
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic              ace_s1;
        logic              ace_s2;
        logic              mode_s1;
        logic              mode_s2;
        logic [ADDR_W-1:0] addr_s1;
        logic [ADDR_W-1:0] addr_s2;
        logic [1:0]        boot_cnt;
        logic              boot_done;
        logic              ace;
        logic              force_x;
        logic              pause_rx;
        logic              pause_tx;
        logic              inject;
        logic              seq;
        logic              run;
        logic              bypass;
        logic              led_mode;
        logic [ADDR_W-1:0] addr;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } state_t;

    state_t q;
    state_t d;

    logic               st_pass;
    logic [COUNT_W-1:0] st_errs;
    logic               access;
    logic               completing;
    logic [15:0]        ctrl_word;
    logic [1:0]         pause_res;

    // ****************************************
    // helpers
    // ****************************************
    // 1 = control register, 2 = count register, 0 = unmapped
    function automatic logic [1:0] decode(input logic [11:0] a);
        if (a == CTRL_ADDR) begin
            decode = 2'h1;
        end else if (a == COUNT_ADDR) begin
            decode = 2'h2;
        end else begin
            decode = 2'h0;
        end
    endfunction

    // {rx, tx} pause resolution; ability is {asym_dir, pause}
    function automatic logic [1:0] resolve(input logic [1:0] loc, input logic [1:0] par);
        if (loc[0] && par[0]) begin
            resolve = 2'h3;
        end else if (loc == 2'h3 && par == 2'h2) begin
            resolve = 2'h2;
        end else if (loc == 2'h2 && par == 2'h3) begin
            resolve = 2'h1;
        end else begin
            resolve = 2'h0;
        end
    endfunction

    assign access     = psel && penable && q.boot_done;
    assign completing = access && q.pready;
    assign pause_res  = resolve(local_pause_ability, partner_pause_ability);

    // reserved bit 6 always reads zero
    always_comb begin
        ctrl_word                          = '0;
        ctrl_word[ACE_BIT]                 = q.ace;
        ctrl_word[FORCE_BIT]               = q.force_x;
        ctrl_word[PAUSE_RX_BIT]            = q.pause_rx;
        ctrl_word[PAUSE_TX_BIT]            = q.pause_tx;
        ctrl_word[INJECT_BIT]              = q.inject;
        ctrl_word[SEQ_BIT]                 = q.seq;
        ctrl_word[PASS_BIT]                = st_pass;
        ctrl_word[RUN_BIT]                 = q.run;
        ctrl_word[BYPASS_BIT]              = q.bypass;
        ctrl_word[MODE_BIT]                = q.led_mode;
        ctrl_word[ADDR_LSB+:ADDR_W]        = q.addr;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;

        // strap synchronisers
        d.ace_s1  = strap_auto_crossover;
        d.ace_s2  = q.ace_s1;
        d.mode_s1 = strap_led_mode;
        d.mode_s2 = q.mode_s1;
        d.addr_s1 = strap_address;
        d.addr_s2 = q.addr_s1;

        // load straps once after reset release
        if (!q.boot_done) begin
            if (q.boot_cnt == BOOT_LOAD) begin
                d.boot_done = 1'b1;
                d.ace       = q.ace_s2;
                d.led_mode  = q.mode_s2;
                d.addr      = q.addr_s2;
            end else begin
                d.boot_cnt = q.boot_cnt + 2'h1;
            end
        end

        // single-error request lasts one cycle
        d.inject = 1'b0;

        // pause bits follow negotiation results only
        if (an_result_valid) begin
            d.pause_rx = an_full_duplex & pause_res[1];
            d.pause_tx = an_full_duplex & pause_res[0];
        end

        // APB: one wait state, answer registered
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (access && !q.pready) begin
            d.pready = 1'b1;
            unique case (decode(paddr))
                2'h1: d.prdata = {16'h0000, ctrl_word};
                2'h2: d.prdata = {{(32-COUNT_W){1'b0}}, st_errs};
                default: begin
                    d.prdata  = 32'h0000_0000;
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // write takes effect at the completing edge
        if (completing && pwrite && decode(paddr) == 2'h1) begin
            d.ace      = pwdata[ACE_BIT];
            d.force_x  = pwdata[FORCE_BIT];
            d.inject   = pwdata[INJECT_BIT] & q.run;
            d.seq      = pwdata[SEQ_BIT];
            d.run      = pwdata[RUN_BIT];
            d.bypass   = pwdata[BYPASS_BIT];
            d.led_mode = pwdata[MODE_BIT];
            d.addr     = pwdata[ADDR_LSB+:ADDR_W];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.force_x   <= RST_FORCE;
            q.pause_rx  <= RST_PAUSE;
            q.pause_tx  <= RST_PAUSE;
            q.inject    <= RST_INJECT;
            q.seq       <= RST_SEQ;
            q.run       <= RST_RUN;
            q.bypass    <= RST_BYPASS;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // self-test
    // ****************************************
    selftest_prbs u_selftest (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .selftest_run             (q.run),
        .selftest_sequence_select (q.seq),
        .selftest_error_inject    (q.inject),
        .selftest_rx_bit          (selftest_rx_bit),
        .selftest_tx_bit          (selftest_tx_bit),
        .selftest_pass_flag       (st_pass),
        .selftest_error_count     (st_errs)
    );

    // ****************************************
    // indicators
    // ****************************************
    led_driver #(
        .STRETCH_CYCLES (STRETCH_CYCLES),
        .BLINK_CYCLES   (BLINK_CYCLES)
    ) u_led (
        .pclk               (pclk),
        .presetn            (presetn),
        .led_mode_select    (q.led_mode),
        .led_stretch_bypass (q.bypass),
        .link_good          (link_good),
        .activity           (activity),
        .speed_100          (speed_100),
        .link_indicator     (link_indicator),
        .speed_indicator    (speed_indicator)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign prdata                = q.prdata;
    assign pready                = q.pready;
    assign pslverr               = q.pslverr;
    assign auto_crossover_enable = q.ace;
    assign crossover_force       = q.force_x;
    assign pause_rx_enable       = q.pause_rx;
    assign pause_tx_enable       = q.pause_tx;
    assign management_address    = q.addr;

endmodule // phy_control_register

// *** verilog/phy_ctrl_pkg.sv ***
// constants shared by the transceiver control register block
package phy_ctrl_pkg;

    // ****************************************
    // register map (index, byte address = index * 4)
    // ****************************************
    localparam logic [7:0]  CTRL_INDEX      = 8'h19;
    localparam logic [7:0]  COUNT_INDEX     = 8'h1C;
    localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_INDEX, 2'h0};
    localparam logic [11:0] COUNT_ADDR      = {2'h0, COUNT_INDEX, 2'h0};

    // ****************************************
    // transceiver_control field positions
    // ****************************************
    localparam int ACE_BIT       = 15;
    localparam int FORCE_BIT     = 14;
    localparam int PAUSE_RX_BIT  = 13;
    localparam int PAUSE_TX_BIT  = 12;
    localparam int INJECT_BIT    = 11;
    localparam int SEQ_BIT       = 10;
    localparam int PASS_BIT      = 9;
    localparam int RUN_BIT       = 8;
    localparam int BYPASS_BIT    = 7;
    localparam int MODE_BIT      = 5;
    localparam int ADDR_LSB      = 0;
    localparam int ADDR_W        = 5;

    // ****************************************
    // reset values of non-strap fields
    // ****************************************
    localparam logic RST_FORCE   = 1'b0;
    localparam logic RST_PAUSE   = 1'b0;
    localparam logic RST_INJECT  = 1'b0;
    localparam logic RST_SEQ     = 1'b0;
    localparam logic RST_PASS    = 1'b0;
    localparam logic RST_RUN     = 1'b0;
    localparam logic RST_BYPASS  = 1'b0;

    // ****************************************
    // strap load and self-test
    // ****************************************
    localparam logic [1:0] BOOT_LOAD    = 2'h2;
    localparam int         COUNT_W      = 8;
    localparam logic [3:0] CHK_FILL     = 4'hF;
    localparam logic [14:0] PRBS_SEED   = 15'h7FFF;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STRETCH_MS    = 50;
    localparam int BLINK_MS      = 100;
    localparam int STRETCH_CYC   = STRETCH_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int BLINK_CYC     = BLINK_MS * (1000000000 / CLK_PERIOD_PS);

    // feedback bit of the selected pseudo-random sequence
    function automatic logic prbs_feedback(input logic [14:0] sr, input logic fifteen);
        prbs_feedback = fifteen ? (sr[14] ^ sr[13]) : (sr[8] ^ sr[4]);
    endfunction

endpackage

// *** verilog/selftest_prbs.sv ***
// packet self-test pattern generator and checker
`timescale 1ns/1ps
module selftest_prbs
    import phy_ctrl_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               selftest_run,
    input  wire logic               selftest_sequence_select,
    input  wire logic               selftest_error_inject,
    input  wire logic               selftest_rx_bit,
    output logic                    selftest_tx_bit,
    output logic                    selftest_pass_flag,
    output logic [COUNT_W-1:0]      selftest_error_count
);

    typedef struct packed {
        logic [14:0]        gen_sr;
        logic [14:0]        chk_sr;
        logic [3:0]         fill;
        logic               tx_bit;
        logic               pass;
        logic               run;
        logic [COUNT_W-1:0] errs;
    } st_state_t;

    st_state_t q;
    st_state_t d;
    logic      gen_fb;
    logic      mismatch;

    assign gen_fb   = prbs_feedback(q.gen_sr, selftest_sequence_select);
    assign mismatch = selftest_rx_bit != prbs_feedback(q.chk_sr, selftest_sequence_select);

    always_comb begin
        d     = q;
        d.run = selftest_run;
        if (selftest_run && !q.run) begin
            // first bit leaves at start, so the checker never takes a stale bit
            d.tx_bit = prbs_feedback(PRBS_SEED, selftest_sequence_select);
            d.gen_sr = {PRBS_SEED[13:0], d.tx_bit};
            d.chk_sr = '0;
            d.fill   = '0;
            d.pass   = 1'b1;
            d.errs   = '0;
        end else if (selftest_run) begin
            d.gen_sr = {q.gen_sr[13:0], gen_fb};
            d.tx_bit = gen_fb ^ selftest_error_inject;
            d.chk_sr = {q.chk_sr[13:0], selftest_rx_bit};
            if (q.fill != CHK_FILL) begin
                d.fill = q.fill + 4'h1;
            end else if (mismatch) begin
                d.pass = 1'b0;
                if (q.errs != '1) begin
                    d.errs = q.errs + 1'b1;
                end
            end
        end else begin
            d.pass   = 1'b0;
            d.tx_bit = 1'b0;
            d.fill   = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign selftest_tx_bit      = q.tx_bit;
    assign selftest_pass_flag   = q.pass;
    assign selftest_error_count = q.errs;

endmodule // selftest_prbs

// *** verilog/led_driver.sv ***
// link and speed indicator drivers with activity stretching
`timescale 1ns/1ps
module led_driver
    import phy_ctrl_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = STRETCH_CYC,
    parameter int unsigned BLINK_CYCLES   = BLINK_CYC
)(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic led_mode_select,
    input  wire logic led_stretch_bypass,
    input  wire logic link_good,
    input  wire logic activity,
    input  wire logic speed_100,
    output logic      link_indicator,
    output logic      speed_indicator
);

    typedef struct packed {
        logic [31:0] stretch;
        logic [31:0] blink;
        logic        phase;
        logic        link;
        logic        speed;
    } led_state_t;

    led_state_t q;
    led_state_t d;
    logic       blink_tick;
    logic       act_on;

    assign blink_tick = q.blink == BLINK_CYCLES - 1;
    assign act_on     = q.stretch != '0;

    always_comb begin
        d       = q;
        d.blink = blink_tick ? '0 : q.blink + 32'h1;
        if (blink_tick) begin
            d.phase = ~q.phase;
        end
        if (activity) begin
            d.stretch = STRETCH_CYCLES;
        end else if (act_on) begin
            d.stretch = q.stretch - 32'h1;
        end
        if (led_mode_select) begin
            d.link = link_good;
        end else if (led_stretch_bypass) begin
            d.link = link_good & ~activity;
        end else begin
            d.link = act_on ? (link_good & q.phase) : link_good;
        end
        d.speed = speed_100;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link_indicator  = q.link;
    assign speed_indicator = q.speed;

endmodule // led_driver

// *** verification/phy_control_register_properties.sv ***
// concurrent checks on the transceiver control register ports
`timescale 1ns/1ps
module phy_control_register_properties
    import phy_ctrl_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              an_result_valid,
    input wire logic              an_full_duplex,
    input wire logic [1:0]        local_pause_ability,
    input wire logic [1:0]        partner_pause_ability,
    input wire logic              auto_crossover_enable,
    input wire logic              crossover_force,
    input wire logic              pause_rx_enable,
    input wire logic              pause_tx_enable,
    input wire logic [ADDR_W-1:0] management_address
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == CTRL_ADDR;
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_answer_bound; psel && penable && !pready |-> ##[0:12] pready; endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("no answer");
    property p_slverr_map; pready |-> pslverr == !(paddr == CTRL_ADDR || paddr == COUNT_ADDR); endproperty
    a_slverr_map: assert property (p_slverr_map) else $error("bad error flag");
    property p_upper_zero; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper half set");
    property p_write_fields;
        logic [31:0] d;
        (wr_ctrl, d = pwdata) |=> {auto_crossover_enable, crossover_force} == d[15:14] && management_address == d[4:0];
    endproperty
    a_write_fields: assert property (p_write_fields) else $error("field not written");
    property p_force_hold; !wr_ctrl |=> $stable(crossover_force); endproperty
    a_force_hold: assert property (p_force_hold) else $error("force moved");
    property p_pause_hold; !an_result_valid |=> $stable({pause_rx_enable, pause_tx_enable}); endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause moved");
    property p_pause_half; an_result_valid && !an_full_duplex |=> !pause_rx_enable && !pause_tx_enable; endproperty
    a_pause_half: assert property (p_pause_half) else $error("pause in half duplex");
    property p_pause_sym;
        an_result_valid && an_full_duplex && local_pause_ability[0] && partner_pause_ability[0]
            |=> pause_rx_enable && pause_tx_enable;
    endproperty
    a_pause_sym: assert property (p_pause_sym) else $error("symmetric pause lost");
    c_write: cover property (wr_ctrl);
    c_refused: cover property (pready && pslverr);
    c_pause: cover property (an_result_valid ##1 pause_rx_enable && pause_tx_enable);
endmodule // phy_control_register_properties

// *** verification/mgmt_host_model.sv ***
// management host model speaking the register bus
`timescale 1ns/1ps
module mgmt_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d & 32'hFFFF_FFBF;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
endmodule // mgmt_host_model

// *** verification/phy_control_register_tb.sv ***
// self-checking bench for the transceiver control register
`timescale 1ns/1ps
module phy_control_register_tb
    import phy_ctrl_pkg::*;
;
    logic              pclk = 1'h0;
    logic              presetn = 1'h0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, x, r, cnt;
    logic              strap_auto_crossover, strap_led_mode, an_result_valid, an_full_duplex;
    logic [ADDR_W-1:0] strap_address, management_address;
    logic [1:0]        local_pause_ability, partner_pause_ability, pz;
    logic              link_good, activity, speed_100, selftest_rx_bit, selftest_tx_bit, e;
    logic              auto_crossover_enable, crossover_force, pause_rx_enable, pause_tx_enable;
    logic              link_indicator, speed_indicator;
    logic [31:0]       seed = 32'hDF826A06;
    logic [15:0]       wv;
    int                num_errors = 0;
    int                samples_checked = 0;
    int                lo;

    phy_control_register #(.STRETCH_CYCLES(8), .BLINK_CYCLES(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_auto_crossover(strap_auto_crossover), .strap_led_mode(strap_led_mode),
        .strap_address(strap_address), .an_result_valid(an_result_valid), .an_full_duplex(an_full_duplex),
        .local_pause_ability(local_pause_ability), .partner_pause_ability(partner_pause_ability),
        .link_good(link_good), .activity(activity), .speed_100(speed_100),
        .selftest_rx_bit(selftest_rx_bit), .selftest_tx_bit(selftest_tx_bit),
        .auto_crossover_enable(auto_crossover_enable), .crossover_force(crossover_force),
        .pause_rx_enable(pause_rx_enable), .pause_tx_enable(pause_tx_enable),
        .management_address(management_address), .link_indicator(link_indicator),
        .speed_indicator(speed_indicator)
    );
    mgmt_host_model u_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    assign selftest_rx_bit = selftest_tx_bit;

    always #2.5 pclk = ~pclk;

    // ********
    // helpers
    // ********
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {rx, tx} from {full duplex, partner, local}
    function automatic logic [1:0] pause_res(input logic [4:0] v);
        if (!v[4]) return 2'h0;
        if (v[0] && v[2]) return 2'h3;
        if (v[1:0] == 2'h3 && v[3:2] == 2'h2) return 2'h2;
        if (v[1:0] == 2'h2 && v[3:2] == 2'h3) return 2'h1;
        return 2'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        u_host.xfer(1'h0, a, 32'h0, q, e);
    endtask
    task automatic chk_ctrl(input logic p, input string m);
        rd(CTRL_ADDR, r);
        chk(r, {16'h0, wv | {2'h0, pz, 2'h0, p, 9'h000}}, m);
    endtask
    task automatic led_run(input logic byp);
        repeat (16) begin
            x = rnd();
            @(posedge pclk);
            {speed_100, activity, link_good} <= x[2:0];
            @(posedge pclk);
            @(negedge pclk);
            chk(32'(link_indicator), 32'(x[0] & ~(byp & x[1])), "link led");
            chk(32'(speed_indicator), 32'(x[2]), "speed led");
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        $display("BAD %0t watchdog", $time);
        num_errors++;
        test_done();
    end

    // ********
    // scenarios
    // ********
    initial begin
        x = rnd();
        {strap_auto_crossover, strap_led_mode, strap_address} = x[6:0];
        {an_result_valid, an_full_duplex, local_pause_ability, partner_pause_ability} = 6'h00;
        {link_good, activity, speed_100} = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        wv = {strap_auto_crossover, 9'h000, strap_led_mode, strap_address};
        pz = 2'h0;
        chk_ctrl(1'h0, "reset value");
        repeat (12) begin
            x = rnd();
            wr(CTRL_ADDR, x & 32'hFFFF_FEFF);
            wv = x[15:0] & 16'hC4BF;
            chk_ctrl(1'h0, "random write");
        end
        wr(12'h068, 32'h0000_FFFF);
        chk(32'(e), 32'h1, "unmapped write");
        rd(12'h068, r);
        chk({r[31:1], e}, 32'h1, "unmapped read");
        chk_ctrl(1'h0, "after unmapped");
        wr(COUNT_ADDR, 32'h0000_00FF);
        rd(COUNT_ADDR, r);
        chk(r, 32'h0, "count idle");
        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            {an_full_duplex, partner_pause_ability, local_pause_ability} <= 5'(i);
            an_result_valid <= 1'h1;
            @(posedge pclk);
            an_result_valid <= 1'h0;
            pz = pause_res(5'(i));
            @(negedge pclk);
            chk(32'({pause_rx_enable, pause_tx_enable}), 32'(pz), "pause pins");
            wr(CTRL_ADDR, {16'h0, wv | {2'h0, ~pz, 12'h000}});
            chk_ctrl(1'h0, "pause bits");
        end
        wv = wv & 16'h7FFF;
        wr(CTRL_ADDR, {16'h0, wv});
        @(negedge pclk);
        chk(32'({auto_crossover_enable, crossover_force, management_address}),
            32'({wv[15:14], wv[4:0]}), "control pins");
        for (int s = 0; s < 2; s++) begin
            wv = (wv & 16'hFAFF) | 16'h0100 | (16'(s) << 10);
            wr(CTRL_ADDR, {16'h0, wv});
            repeat (40) @(posedge pclk);
            chk_ctrl(1'h1, "self-test pass");
            wr(CTRL_ADDR, {16'h0, wv | 16'h0800});
            repeat (40) @(posedge pclk);
            chk_ctrl(1'h0, "after inject");
            rd(COUNT_ADDR, cnt);
            chk(32'(cnt > 0 && cnt < 4), 32'h1, "error count");
            wv = wv & 16'hFEFF;
            wr(CTRL_ADDR, {16'h0, wv});
            chk_ctrl(1'h0, "stopped");
            rd(COUNT_ADDR, r);
            chk(r, cnt, "count holds");
        end
        wv = (wv & 16'hFF5F) | 16'h0020;
        wr(CTRL_ADDR, {16'h0, wv});
        led_run(1'h0);
        wv = (wv & 16'hFFDF) | 16'h0080;
        wr(CTRL_ADDR, {16'h0, wv});
        led_run(1'h1);
        wv = wv & 16'hFF7F;
        wr(CTRL_ADDR, {16'h0, wv});
        @(posedge pclk);
        {link_good, activity} <= 2'h3;
        @(posedge pclk);
        activity <= 1'h0;
        lo = 0;
        repeat (12) begin
            @(negedge pclk);
            lo += int'(link_indicator === 1'h0);
        end
        chk(32'(lo > 0), 32'h1, "blink on activity");
        repeat (20) @(negedge pclk);
        chk(32'(link_indicator), 32'h1, "steady link");
        test_done();
    end
endmodule // phy_control_register_tb

bind phy_control_register phy_control_register_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .an_result_valid(an_result_valid),
    .an_full_duplex(an_full_duplex), .local_pause_ability(local_pause_ability),
    .partner_pause_ability(partner_pause_ability), .auto_crossover_enable(auto_crossover_enable),
    .crossover_force(crossover_force), .pause_rx_enable(pause_rx_enable), .pause_tx_enable(pause_tx_enable),
    .management_address(management_address)
);
